/* File: hw/flsc_ctrl.sv */
// Program flash self-read, erase and write controller with its registers
`timescale 1ns/100ps
`default_nettype none

module flsc_ctrl
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [flsc_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic [flsc_pkg::ADDR_W:0] flash_addr_o,
  output logic [flsc_pkg::WORD_W-1:0] flash_wdata_o,
  output logic flash_rd_o,
  output logic flash_wr_o,
  output logic flash_erase_o,
  input wire logic [flsc_pkg::WORD_W-1:0] flash_rdata_i,
  output logic cpu_stall_o,
  output logic cpu_skip_o
);

  // Readable set of the configuration space
  function automatic logic cfg_readable(
    input logic [flsc_pkg::ADDR_W-1:0] a);
    cfg_readable = (a <= flsc_pkg::CFG_UID_LAST) ||
                   (a == flsc_pkg::CFG_DEV_ID) ||
                   (a == flsc_pkg::CFG_WORD1) ||
                   (a == flsc_pkg::CFG_WORD2);
  endfunction

  // Only the user IDs take writes in configuration space
  function automatic logic may_write(input logic cfg,
    input logic [flsc_pkg::ADDR_W-1:0] a);
    may_write = !cfg || (a <= flsc_pkg::CFG_UID_LAST);
  endfunction

  logic [7:0] adr_lo_ff;
  logic [6:0] adr_hi_ff;
  logic [7:0] dat_lo_ff;
  logic [5:0] dat_hi_ff;
  logic config_space_select_ff;
  logic latch_load_only_ff;
  logic free_ff;
  logic program_error_flag_ff;
  logic program_enable_ff;
  logic wr_ff;
  logic rd_ff;
  flsc_pkg::flsc_unlock_t unlock_ff;
  flsc_pkg::flsc_state_t state_ff;
  logic [flsc_pkg::WORD_W-1:0] latch_mem [flsc_pkg::LATCH_CNT];
  logic [flsc_pkg::LATCH_IDX_W-1:0] idx_ff;
  logic [flsc_pkg::ROW_W-1:0] op_row_ff;
  logic op_config_space_select_ff;
  logic op_flash_ff;
  logic op_erase_ff;
  logic [flsc_pkg::ADDR_W:0] flash_addr_ff;
  logic [flsc_pkg::WORD_W-1:0] flash_wdata_ff;
  logic flash_rd_ff;
  logic flash_wr_ff;
  logic flash_erase_ff;
  logic cap_ff;
  logic rd_ok_ff;
  logic [7:0] rdata_ff;

  logic [flsc_pkg::ADDR_W-1:0] word_addr;
  logic [flsc_pkg::ADDR_W-1:0] stream_addr;
  logic wr_ctl;
  logic wr_attempt;
  logic start_ok;
  logic rd_start;
  logic new_config_space_select;
  logic new_free;
  logic new_latch_load_only;
  logic tmr_load;
  logic [flsc_pkg::TIMER_W-1:0] tmr_value;
  logic tmr_done;

  assign word_addr = {adr_hi_ff, adr_lo_ff};
  assign stream_addr = {op_row_ff, idx_ff};
  assign new_config_space_select = reg_wdata_i[flsc_pkg::CTL_CONFIG_SPACE_SELECT];
  assign new_free = reg_wdata_i[flsc_pkg::CTL_FREE];
  assign new_latch_load_only = reg_wdata_i[flsc_pkg::CTL_LATCH_LOAD_ONLY];
  assign wr_ctl = reg_wr_i && (reg_addr_i == flsc_pkg::OFS_CONTROL);
  // Any one written to write-start counts as an attempt, legal or not
  assign wr_attempt = wr_ctl && reg_wdata_i[flsc_pkg::CTL_WR];
  // Start needs the armed unlock, enable set and an idle sequencer
  // A write start beside a read start loses, so WR never sticks unserved
  assign start_ok = wr_attempt && (unlock_ff == flsc_pkg::UNL_ARMED) &&
                    reg_wdata_i[flsc_pkg::CTL_PROGRAM_ENABLE] && !rd_start &&
                    (state_ff == flsc_pkg::ST_IDLE) && !rd_ff;
  assign rd_start = wr_ctl && reg_wdata_i[flsc_pkg::CTL_RD] && !rd_ff &&
                    (state_ff == flsc_pkg::ST_IDLE);

  // Timer is loaded when the flash action is issued
  always_comb
  begin
    tmr_load = 1'b0;
    tmr_value = flsc_pkg::PROG_CYCLES;
    if ((state_ff == flsc_pkg::ST_IDLE) && start_ok && new_free &&
        may_write(new_config_space_select, word_addr))
    begin
      tmr_load = 1'b1;
      tmr_value = flsc_pkg::ERASE_CYCLES;
    end
    else if ((state_ff == flsc_pkg::ST_STREAM) &&
             (idx_ff == flsc_pkg::LAST_LATCH))
    begin
      tmr_load = 1'b1;
    end
  end

  flsc_op_timer u_timer
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(tmr_load),
    .load_value_i(tmr_value),
    .busy_o(),
    .done_o(tmr_done)
  );

  // Unlock tracker: any other register write breaks the sequence
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      unlock_ff <= flsc_pkg::UNL_NONE;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i != flsc_pkg::OFS_UNLOCK)
      begin
        unlock_ff <= flsc_pkg::UNL_NONE;
      end
      else if (reg_wdata_i == flsc_pkg::UNLOCK_KEY1)
      begin
        unlock_ff <= flsc_pkg::UNL_GOT1;
      end
      else if ((reg_wdata_i == flsc_pkg::UNLOCK_KEY2) &&
               (unlock_ff == flsc_pkg::UNL_GOT1))
      begin
        unlock_ff <= flsc_pkg::UNL_ARMED;
      end
      else
      begin
        unlock_ff <= flsc_pkg::UNL_NONE;
      end
    end
  end

  // Address registers; bit 7 of the high byte is not stored
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      adr_lo_ff <= 8'h00;
      adr_hi_ff <= 7'h00;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == flsc_pkg::OFS_ADDR_LOW)
      begin
        adr_lo_ff <= reg_wdata_i;
      end
      if (reg_addr_i == flsc_pkg::OFS_ADDR_HIGH)
      begin
        adr_hi_ff <= reg_wdata_i[6:0];
      end
    end
  end

  // Data registers; a finished fetch overrides a software write
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      dat_lo_ff <= 8'h00;
      dat_hi_ff <= 6'h00;
    end
    else if (cap_ff)
    begin
      dat_lo_ff <= rd_ok_ff ? flash_rdata_i[7:0] : 8'h00;
      dat_hi_ff <= rd_ok_ff ? flash_rdata_i[13:8] : 6'h00;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == flsc_pkg::OFS_DATA_LOW)
      begin
        dat_lo_ff <= reg_wdata_i;
      end
      if (reg_addr_i == flsc_pkg::OFS_DATA_HIGH)
      begin
        dat_hi_ff <= reg_wdata_i[5:0];
      end
    end
  end

  // Plain control bits
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      config_space_select_ff <= 1'b0;
      latch_load_only_ff <= 1'b0;
      program_enable_ff <= 1'b0;
    end
    else if (wr_ctl)
    begin
      config_space_select_ff <= new_config_space_select;
      latch_load_only_ff <= new_latch_load_only;
      program_enable_ff <= reg_wdata_i[flsc_pkg::CTL_PROGRAM_ENABLE];
    end
  end

  // Erase select: held through an operation, dropped when erase ends
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      free_ff <= 1'b0;
    end
    else if ((state_ff == flsc_pkg::ST_DONE) && op_erase_ff)
    begin
      free_ff <= 1'b0;
    end
    else if (wr_ctl && (state_ff == flsc_pkg::ST_IDLE))
    begin
      free_ff <= new_free;
    end
  end

  // Error flag: set on attempt wins over clear and over software write
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      program_error_flag_ff <= 1'b0;
    end
    else if (wr_attempt)
    begin
      program_error_flag_ff <= 1'b1;
    end
    else if (state_ff == flsc_pkg::ST_DONE)
    begin
      program_error_flag_ff <= 1'b0;
    end
    else if (wr_ctl)
    begin
      program_error_flag_ff <= reg_wdata_i[flsc_pkg::CTL_PROGRAM_ERROR_FLAG];
    end
  end

  // Start bits are set only by software and cleared only by hardware
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
    end
    else
    begin
      if (start_ok)
      begin
        wr_ff <= 1'b1;
      end
      else if (state_ff == flsc_pkg::ST_DONE)
      begin
        wr_ff <= 1'b0;
      end
      if (rd_start)
      begin
        rd_ff <= 1'b1;
      end
      else if (cap_ff)
      begin
        rd_ff <= 1'b0;
      end
    end
  end

  // Write latches: loaded by a non-erase start, blanked after flash ops
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < flsc_pkg::LATCH_CNT; i++)
      begin
        latch_mem[i] <= flsc_pkg::BLANK_WORD;
      end
    end
    else if ((state_ff == flsc_pkg::ST_DONE) && op_flash_ff)
    begin
      for (int i = 0; i < flsc_pkg::LATCH_CNT; i++)
      begin
        latch_mem[i] <= flsc_pkg::BLANK_WORD;
      end
    end
    else if (start_ok && !new_free)
    begin
      latch_mem[adr_lo_ff[flsc_pkg::LATCH_IDX_W-1:0]] <=
        {dat_hi_ff, dat_lo_ff};
    end
  end

  // Operation sequencer and flash command outputs
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_ff <= flsc_pkg::ST_IDLE;
      idx_ff <= '0;
      op_row_ff <= '0;
      op_config_space_select_ff <= 1'b0;
      op_flash_ff <= 1'b0;
      op_erase_ff <= 1'b0;
      flash_addr_ff <= '0;
      flash_wdata_ff <= '0;
      flash_rd_ff <= 1'b0;
      flash_wr_ff <= 1'b0;
      flash_erase_ff <= 1'b0;
      cap_ff <= 1'b0;
      rd_ok_ff <= 1'b0;
    end
    else
    begin
      flash_rd_ff <= 1'b0;
      flash_wr_ff <= 1'b0;
      flash_erase_ff <= 1'b0;
      cap_ff <= flash_rd_ff;
      case (state_ff)
        flsc_pkg::ST_IDLE:
        begin
          op_flash_ff <= 1'b0;
          op_erase_ff <= 1'b0;
          if (rd_start)
          begin
            flash_rd_ff <= 1'b1;
            flash_addr_ff <= {new_config_space_select, word_addr};
            rd_ok_ff <= !new_config_space_select || cfg_readable(word_addr);
          end
          else if (start_ok)
          begin
            op_row_ff <= word_addr[flsc_pkg::ADDR_W-1:flsc_pkg::LATCH_IDX_W];
            op_config_space_select_ff <= new_config_space_select;
            idx_ff <= '0;
            if (new_free)
            begin
              // Erase of a read-only config location does nothing
              op_erase_ff <= 1'b1;
              if (may_write(new_config_space_select, word_addr))
              begin
                flash_erase_ff <= 1'b1;
                flash_addr_ff <= {new_config_space_select, word_addr};
                op_flash_ff <= 1'b1;
                state_ff <= flsc_pkg::ST_WAIT;
              end
              else
              begin
                state_ff <= flsc_pkg::ST_DONE;
              end
            end
            else if (new_latch_load_only)
            begin
              state_ff <= flsc_pkg::ST_DONE;
            end
            else
            begin
              op_flash_ff <= 1'b1;
              state_ff <= flsc_pkg::ST_STREAM;
            end
          end
        end
        flsc_pkg::ST_STREAM:
        begin
          // One latch per cycle, all within the captured row
          flash_wr_ff <= may_write(op_config_space_select_ff, stream_addr);
          flash_addr_ff <= {op_config_space_select_ff, stream_addr};
          flash_wdata_ff <= latch_mem[idx_ff];
          idx_ff <= idx_ff + 1'b1;
          if (idx_ff == flsc_pkg::LAST_LATCH)
          begin
            state_ff <= flsc_pkg::ST_WAIT;
          end
        end
        flsc_pkg::ST_WAIT:
        begin
          if (tmr_done)
          begin
            state_ff <= flsc_pkg::ST_DONE;
          end
        end
        flsc_pkg::ST_DONE:
        begin
          state_ff <= flsc_pkg::ST_IDLE;
        end
        default:
        begin
          state_ff <= flsc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Register read port, data valid the cycle after the strobe only
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rdata_ff <= 8'h00;
    end
    else if (!reg_rd_i)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      case (reg_addr_i)
        flsc_pkg::OFS_DATA_LOW: rdata_ff <= dat_lo_ff;
        flsc_pkg::OFS_DATA_HIGH: rdata_ff <= {2'b00, dat_hi_ff};
        flsc_pkg::OFS_ADDR_LOW: rdata_ff <= adr_lo_ff;
        flsc_pkg::OFS_ADDR_HIGH: rdata_ff <= {1'b1, adr_hi_ff};
        flsc_pkg::OFS_CONTROL:
        begin
          rdata_ff <= {1'b1, config_space_select_ff, latch_load_only_ff, free_ff,
                       program_error_flag_ff, program_enable_ff, wr_ff, rd_ff};
        end
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign flash_addr_o = flash_addr_ff;
  assign flash_wdata_o = flash_wdata_ff;
  assign flash_rd_o = flash_rd_ff;
  assign flash_wr_o = flash_wr_ff;
  assign flash_erase_o = flash_erase_ff;
  // Core halts while the self-timed operation runs
  assign cpu_stall_o = (state_ff != flsc_pkg::ST_IDLE);
  // The second instruction after a read start is dropped
  assign cpu_skip_o = cap_ff;

endmodule

`default_nettype wire

/* File: hw/flsc_op_timer.sv */
// Countdown timer for the self-timed program and erase operations
`timescale 1ns/100ps
`default_nettype none

module flsc_op_timer
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [flsc_pkg::TIMER_W-1:0] load_value_i,
  output logic busy_o,
  output logic done_o
);

  logic [flsc_pkg::TIMER_W-1:0] count_ff;
  logic done_ff;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      count_ff <= '0;
    end
    else if (load_i)
    begin
      count_ff <= load_value_i;
    end
    else if (count_ff != '0)
    begin
      count_ff <= count_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= !load_i && (count_ff == flsc_pkg::TIMER_W'(1));
    end
  end

  assign busy_o = (count_ff != '0);
  assign done_o = done_ff;

endmodule

`default_nettype wire

/* File: hw/flsc_pkg.sv */
// Constants and types shared by the flash self-write control block
package flsc_pkg;

  // Clock and self-timed operation lengths
  localparam int CLK_MHZ = 200;
  localparam int PROG_TIME_US = 2;
  localparam int ERASE_TIME_US = 2;
  localparam int TIMER_W = 12;
  localparam logic [TIMER_W-1:0] PROG_CYCLES =
    TIMER_W'(PROG_TIME_US * CLK_MHZ);
  localparam logic [TIMER_W-1:0] ERASE_CYCLES =
    TIMER_W'(ERASE_TIME_US * CLK_MHZ);

  // Register port offsets
  localparam int REG_ADDR_W = 3;
  localparam logic [REG_ADDR_W-1:0] OFS_DATA_LOW = 3'h0;
  localparam logic [REG_ADDR_W-1:0] OFS_DATA_HIGH = 3'h1;
  localparam logic [REG_ADDR_W-1:0] OFS_ADDR_LOW = 3'h2;
  localparam logic [REG_ADDR_W-1:0] OFS_ADDR_HIGH = 3'h3;
  localparam logic [REG_ADDR_W-1:0] OFS_CONTROL = 3'h4;
  localparam logic [REG_ADDR_W-1:0] OFS_UNLOCK = 3'h5;

  // Control register bit positions
  localparam int CTL_RSVD = 7;
  localparam int CTL_CONFIG_SPACE_SELECT = 6;
  localparam int CTL_LATCH_LOAD_ONLY = 5;
  localparam int CTL_FREE = 4;
  localparam int CTL_PROGRAM_ERROR_FLAG = 3;
  localparam int CTL_PROGRAM_ENABLE = 2;
  localparam int CTL_WR = 1;
  localparam int CTL_RD = 0;

  // Unlock pattern
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;

  // Word, address and latch geometry
  localparam int WORD_W = 14;
  localparam int ADDR_W = 15;
  localparam int LATCH_CNT = 32;
  localparam int LATCH_IDX_W = 5;
  localparam int ROW_W = ADDR_W - LATCH_IDX_W;
  localparam logic [WORD_W-1:0] BLANK_WORD = 14'h3FFF;
  localparam logic [LATCH_IDX_W-1:0] LAST_LATCH = 5'h1F;

  // Configuration space map, relative to the space base
  localparam logic [ADDR_W-1:0] CFG_UID_LAST = 15'h0003;
  localparam logic [ADDR_W-1:0] CFG_DEV_ID = 15'h0006;
  localparam logic [ADDR_W-1:0] CFG_WORD1 = 15'h0007;
  localparam logic [ADDR_W-1:0] CFG_WORD2 = 15'h0008;

  typedef enum logic [1:0] {UNL_NONE, UNL_GOT1, UNL_ARMED} flsc_unlock_t;
  typedef enum logic [2:0] {ST_IDLE, ST_STREAM, ST_WAIT, ST_DONE}
    flsc_state_t;

endpackage

/* File: test/flsc_ctrl_monitor.sv */
// Port-level assertions for the flash self-write controller
`timescale 1ns/100ps
`default_nettype none
module flsc_ctrl_monitor
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [flsc_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [flsc_pkg::ADDR_W:0] flash_addr_o,
  input wire logic [flsc_pkg::WORD_W-1:0] flash_wdata_o,
  input wire logic flash_rd_o,
  input wire logic flash_wr_o,
  input wire logic flash_erase_o,
  input wire logic [flsc_pkg::WORD_W-1:0] flash_rdata_i,
  input wire logic cpu_stall_o,
  input wire logic cpu_skip_o
);
  wire logic ctl_w = reg_wr_i && reg_addr_i == flsc_pkg::OFS_CONTROL;
  wire logic rd_cmd_w = ctl_w && reg_wdata_i[flsc_pkg::CTL_RD];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence rd_cmd_s;
    rd_cmd_w && !cpu_stall_o && !flash_rd_o && !cpu_skip_o;
  endsequence
  sequence bad_wr_s;
    ctl_w && reg_wdata_i[flsc_pkg::CTL_WR] &&
      !reg_wdata_i[flsc_pkg::CTL_PROGRAM_ENABLE] && !cpu_stall_o;
  endsequence

  rsvd_one_a: assert property (reg_rd_i && (reg_addr_i ==
    flsc_pkg::OFS_ADDR_HIGH || reg_addr_i == flsc_pkg::OFS_CONTROL)
    |=> reg_rdata_o[7]) else $error("reserved bit not one");
  rd_launch_a: assert property (rd_cmd_s |=> flash_rd_o)
    else $error("read start did not fetch");
  rd_cause_a: assert property (flash_rd_o |-> $past(rd_cmd_w))
    else $error("fetch without read start");
  skip_slot_a: assert property (flash_rd_o |=> cpu_skip_o ##1 !cpu_skip_o)
    else $error("skip slot wrong");
  no_enable_a: assert property (bad_wr_s |=>
    !cpu_stall_o && !flash_erase_o ##1 !flash_wr_o)
    else $error("operation while disabled");
  erase_once_a: assert property (flash_erase_o |=>
    (cpu_stall_o && !flash_erase_o) [*8]) else $error("erase pulse bad");
  row_walk_a: assert property (flash_wr_o && !flash_addr_o[15] &&
    flash_addr_o[4:0] != 5'h1F |=> flash_wr_o &&
    flash_addr_o == $past(flash_addr_o) + 16'h0001)
    else $error("latch walk broken");
  cfg_ro_a: assert property (flash_wr_o && flash_addr_o[15] |->
    flash_addr_o[14:0] <= flsc_pkg::CFG_UID_LAST)
    else $error("read-only config written");
endmodule

bind flsc_ctrl flsc_ctrl_monitor mon
(
  .clk_i(clk_i),
  .reset_i(reset_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .flash_addr_o(flash_addr_o),
  .flash_wdata_o(flash_wdata_o),
  .flash_rd_o(flash_rd_o),
  .flash_wr_o(flash_wr_o),
  .flash_erase_o(flash_erase_o),
  .flash_rdata_i(flash_rdata_i),
  .cpu_stall_o(cpu_stall_o),
  .cpu_skip_o(cpu_skip_o)
);
`default_nettype wire

/* File: test/test_program_flash_self_write_control.sv */
// Self-checking bench for the flash self-write controller
`timescale 1ns/100ps
`default_nettype none
module test_program_flash_self_write_control;
  logic clk_i, reset_i, reg_wr_i, reg_rd_i, flash_rd_o, flash_wr_o;
  logic flash_erase_o, cpu_stall_o, cpu_skip_o;
  logic [2:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, v;
  logic [15:0] flash_addr_o;
  logic [13:0] flash_wdata_o, flash_rdata_i;
  logic [14:0] adr;
  logic [31:0] seed;
  logic [13:0] lat[32];
  logic [29:0] wq[$];
  int mismatches, n_compared, n_erase;

  flsc_ctrl dut
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .flash_addr_o(flash_addr_o),
    .flash_wdata_o(flash_wdata_o),
    .flash_rd_o(flash_rd_o),
    .flash_wr_o(flash_wr_o),
    .flash_erase_o(flash_erase_o),
    .flash_rdata_i(flash_rdata_i),
    .cpu_stall_o(cpu_stall_o),
    .cpu_skip_o(cpu_skip_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Strobes are sampled mid-cycle, clear of the edge that launches them
  always @(negedge clk_i)
  begin
    if (flash_wr_o === 1'b1)
      wq.push_back({flash_addr_o, flash_wdata_o});
    if (flash_erase_o === 1'b1)
      n_erase++;
  end

  function automatic logic [31:0] rnd();
    seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
    return seed;
  endfunction

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk({8'h00, reg_rdata_o}, {8'h00, e});
  endtask

  // Bounded wait: a stuck sequencer shows up as later mismatches
  task automatic op(input logic [7:0] c);
    wr(3'h5, 8'h55);
    wr(3'h5, 8'hAA);
    wr(3'h4, c);
    #1;
    for (int i = 0; i < 1000 && cpu_stall_o !== 1'b0; i++)
      @(posedge clk_i) #1;
  endtask

  task automatic frd(input logic c, input logic [14:0] a);
    logic [13:0] e;
    void'(rnd());
    wr(3'h2, a[7:0]);
    wr(3'h3, {1'b0, a[14:8]});
    flash_rdata_i <= seed[13:0];
    wr(3'h4, {1'b0, c, 6'h01});
    #1;
    chk({15'h0000, flash_rd_o}, 16'h0001);
    chk(flash_addr_o, {c, a});
    chk({14'h0000, cpu_stall_o, cpu_skip_o}, 16'h0000);
    @(posedge clk_i) #1;
    chk({15'h0000, cpu_skip_o}, 16'h0001);
    @(posedge clk_i) #1;
    chk({15'h0000, cpu_skip_o}, 16'h0000);
    @(posedge clk_i);
    e = (!c || a <= 15'h0003 || (a >= 15'h0006 && a <= 15'h0008)) ?
      seed[13:0] : 14'h0000;
    rchk(3'h0, e[7:0]);
    rchk(3'h1, {2'b00, e[13:8]});
  endtask

  task automatic prog(input logic [14:0] a, input logic [7:0] c,
    input logic [7:0] e);
    void'(rnd());
    if (!c[4])
      lat[a[4:0]] = seed[13:0];
    wr(3'h2, a[7:0]);
    wr(3'h3, {1'b0, a[14:8]});
    wr(3'h0, seed[7:0]);
    wr(3'h1, seed[15:8]);
    op(c);
    rchk(3'h4, e);
  endtask

  task automatic row_chk(input logic c, input logic [9:0] r, input int n);
    chk(16'(wq.size()), 16'(n));
    for (int i = 0; i < n && i < wq.size(); i++)
    begin
      chk({2'b00, wq[i][13:0]}, {2'b00, lat[i]});
      chk(wq[i][29:14], {c, r, 5'(i)});
    end
    wq.delete();
    foreach (lat[i])
      lat[i] = 14'h3FFF;
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    seed = 32'h0001314E;
    mismatches = 0;
    n_compared = 0;
    n_erase = 0;
    reset_i = 1'b1;
    reg_addr_i = 3'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    flash_rdata_i = 14'h0000;
    foreach (lat[i])
      lat[i] = 14'h3FFF;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int k = 0; k < 8; k++)
      rchk(3'(k), (k == 3 || k == 4) ? 8'h80 : 8'h00);
    void'(rnd());
    wr(3'h3, seed[7:0]);
    rchk(3'h3, {1'b1, seed[6:0]});
    wr(3'h1, seed[15:8]);
    rchk(3'h1, {2'b00, seed[13:8]});
    wr(3'h4, 8'hEC);
    rchk(3'h4, 8'hEC);
    wr(3'h4, 8'h00);
    rchk(3'h4, 8'h80);
    $display("registers done");
    void'(rnd());
    frd(1'b0, seed[14:0]);
    for (int k = 0; k < 10; k++)
      frd(1'b1, 15'(k));
    $display("reads done");
    wr(3'h4, 8'h06);
    rchk(3'h4, 8'h8C);
    op(8'h02);
    rchk(3'h4, 8'h88);
    chk(16'(wq.size() + n_erase), 16'h0000);
    $display("refusals done");
    void'(rnd());
    adr = {seed[9:0], 5'h00};
    prog(adr | 15'h0003, 8'h26, 8'hA4);
    prog(adr | 15'h001F, 8'h26, 8'hA4);
    chk(16'(wq.size()), 16'h0000);
    prog(adr | 15'h0005, 8'h06, 8'h84);
    row_chk(1'b0, adr[14:5], 32);
    prog(adr, 8'h06, 8'h84);
    row_chk(1'b0, adr[14:5], 32);
    $display("program done");
    prog(adr, 8'h16, 8'h84);
    prog(adr, 8'h36, 8'hA4);
    chk(16'(n_erase), 16'h0002);
    chk(16'(wq.size()), 16'h0000);
    prog(15'h0006, 8'h46, 8'hC4);
    row_chk(1'b1, 10'h000, 4);
    $display("erase and config done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
